// File: logic/dscp_pkg.sv
package dscp_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int DSCP_NUM_REGS = 32;
	localparam logic [4:0] DSCP_REG_CFG = 5'h00;
	localparam logic [4:0] DSCP_REG_PWR = 5'h01;
	localparam logic [4:0] DSCP_REG_DATA = 5'h02;
	localparam logic [4:0] DSCP_REG_MEMDATA = 5'h11;
	localparam logic [4:0] DSCP_REG_CLKMODE = 5'h14;
	localparam logic [4:0] DSCP_REG_VERSION = 5'h1F;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int DSCP_INS_RW = 7;
	localparam int DSCP_INS_CNT_HI = 6;
	localparam int DSCP_INS_CNT_LO = 5;
	localparam int DSCP_INS_ADDR_TOP = 4;
	localparam int DSCP_CFG_BIT_ORDER = 6;
	localparam int DSCP_CFG_SOFT_RST = 5;
	localparam int DSCP_CFG_LONG_ADDR = 4;
	localparam logic [7:0] DSCP_CFG_WMASK = 8'h70;
	localparam int DSCP_PWR_DOWN_BIT = 5;
	localparam int DSCP_DATA_FMT_BIT = 7;
	localparam int DSCP_CLKMODE_EN_BIT = 2;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] DSCP_CFG_RST = 8'h00;
	localparam logic [7:0] DSCP_PWR_RST = 8'h40;
	localparam logic [7:0] DSCP_DATA_RST = 8'h34;
	localparam logic [7:0] DSCP_MEMDATA_RST = 8'h34;
	localparam logic [7:0] DSCP_OTHER_RST = 8'h00;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int DSCP_CLK_PERIOD_NS = 10;
	localparam int DSCP_FMT_SETTLE_NS = 1000;
	localparam int DSCP_FMT_SETTLE_CYC =
		(DSCP_FMT_SETTLE_NS + DSCP_CLK_PERIOD_NS - 1) / DSCP_CLK_PERIOD_NS;
	localparam logic [2:0] DSCP_BIT_LAST = 3'h7;

	typedef enum logic [1:0] {
		ST_INSTR,
		ST_ADDR_LO,
		ST_DATA,
		ST_DONE
	} dscp_state_t;

	function automatic logic [7:0] dscp_def(input int idx);
		case (idx)
			1: dscp_def = DSCP_PWR_RST;
			2: dscp_def = DSCP_DATA_RST;
			17: dscp_def = DSCP_MEMDATA_RST;
			default: dscp_def = DSCP_OTHER_RST;
		endcase
	endfunction

endpackage

// File: logic/dscp_pin_if.sv
`timescale 1ns/10ps
interface dscp_pin_if;
	logic pinmode;
	logic clock_mode_pin;
	logic format;
	logic pwrdn;
	modport prod (
		output pinmode,
		output clock_mode_pin,
		output format,
		output pwrdn
	);
	modport cons (
		input pinmode,
		input clock_mode_pin,
		input format,
		input pwrdn
	);
endinterface

// File: logic/dscp_pin_sync.sv
`timescale 1ns/10ps
module dscp_pin_sync
	import dscp_pkg::*;
#(
	parameter int SETTLE_CYC = DSCP_FMT_SETTLE_CYC
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic sclk_i,
	input wire logic sdio_i,
	input wire logic select_powerdown_n_i,
	input wire logic port_reset_pinmode_i,
	dscp_pin_if.prod pins
);

	// ----------------------------------------
	// Two-stage synchronisers
	// ----------------------------------------
	logic [3:0] meta_r;
	logic [3:0] sync_r;
	logic fmt_r;
	logic [15:0] fmt_cnt_r;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			meta_r <= 4'h0;
			sync_r <= 4'h0;
		end else begin
			meta_r <= {port_reset_pinmode_i, sclk_i, sdio_i,
				select_powerdown_n_i};
			sync_r <= meta_r;
		end
	end

	// ----------------------------------------
	// Format pin settle filter
	// ----------------------------------------
	// Pins are not latched; a new format level is followed after it settles
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			fmt_r <= 1'b0;
			fmt_cnt_r <= 16'h0000;
		end else if (sync_r[1] == fmt_r) begin
			fmt_cnt_r <= 16'h0000;
		end else if (fmt_cnt_r == 16'(SETTLE_CYC - 1)) begin
			fmt_r <= sync_r[1];
			fmt_cnt_r <= 16'h0000;
		end else begin
			fmt_cnt_r <= fmt_cnt_r + 16'h0001;
		end
	end

	assign pins.pinmode = sync_r[3];
	assign pins.clock_mode_pin = sync_r[2];
	assign pins.format = fmt_r;
	assign pins.pwrdn = sync_r[0];

endmodule

// File: logic/dscp_top.sv
`timescale 1ns/10ps
module dscp_top
	import dscp_pkg::*;
#(
	parameter logic [7:0] VERSION_ID = 8'h5A, // Arbitrary value
	parameter int SETTLE_CYC = DSCP_FMT_SETTLE_CYC
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic sclk_i,
	input wire logic select_powerdown_n_i,
	input wire logic sdio_i,
	output logic sdio_o,
	output logic sdio_oe_n_o,
	input wire logic port_reset_pinmode_i,
	output logic pin_mode_o,
	output logic clock_mode_o,
	output logic data_format_o,
	output logic powerdown_o
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic rst_hold_r;
	logic regs_rst;
	logic seq_rst;
	dscp_state_t state_r;
	logic [2:0] bit_cnt_r;
	logic [7:0] shift_r;
	logic [7:0] rx_byte;
	logic byte_done;
	logic rw_r;
	logic [1:0] left_r;
	logic [12:0] addr_r;
	logic [12:0] addr_nxt;
	logic mapped;
	logic [4:0] idx;
	logic wr_en;
	logic [7:0] cfg_r;
	logic bit_order_select;
	logic long_address_select;
	logic soft_rst;
	logic next_lsb;
	logic [7:0] reg_q [DSCP_NUM_REGS];
	logic [7:0] rd_byte;
	logic [2:0] tx_idx;
	logic drive_rd;
	logic [2:0] core_src;
	logic [2:0] core_sync;
	logic [3:0] func_nxt;
	dscp_pin_if pins ();

	// ----------------------------------------
	// Reset sources for the link domain
	// ----------------------------------------
	// Serial clock may be stopped, so resets act without it
	always_ff @(posedge clk_i) begin
		rst_hold_r <= srst_i;
	end

	assign regs_rst = port_reset_pinmode_i | rst_hold_r;
	// Select high or pin reset restarts sequencing
	assign seq_rst = select_powerdown_n_i | regs_rst;

	// ----------------------------------------
	// Configuration register
	// ----------------------------------------
	assign bit_order_select = cfg_r[DSCP_CFG_BIT_ORDER];
	assign long_address_select = cfg_r[DSCP_CFG_LONG_ADDR];
	assign soft_rst = cfg_r[DSCP_CFG_SOFT_RST];

	// Reserved bits are kept at zero
	always_ff @(posedge sclk_i or posedge regs_rst) begin
		if (regs_rst) begin
			cfg_r <= DSCP_CFG_RST;
		end else if (wr_en && idx == DSCP_REG_CFG) begin
			cfg_r <= rx_byte & DSCP_CFG_WMASK;
		end
	end

	// ----------------------------------------
	// Bit shifter
	// ----------------------------------------
	always_comb begin
		if (bit_order_select) begin
			rx_byte = {sdio_i, shift_r[7:1]};
		end else begin
			rx_byte = {shift_r[6:0], sdio_i};
		end
	end

	assign byte_done = bit_cnt_r == DSCP_BIT_LAST;

	// Partial bits vanish with the reset
	always_ff @(posedge sclk_i or posedge seq_rst) begin
		if (seq_rst) begin
			bit_cnt_r <= 3'h0;
			shift_r <= 8'h00;
		end else begin
			bit_cnt_r <= bit_cnt_r + 3'h1;
			shift_r <= rx_byte;
		end
	end

	// ----------------------------------------
	// Address handling
	// ----------------------------------------
	// Long address space beyond the map is not backed
	assign mapped = addr_r[12:5] == 8'h00;
	assign idx = addr_r[4:0];
	assign wr_en = state_r == ST_DATA && byte_done && !rw_r && mapped;

	// Bit order written by this very byte steers the step
	assign next_lsb = (wr_en && idx == DSCP_REG_CFG) ?
		rx_byte[DSCP_CFG_BIT_ORDER] : bit_order_select;

	always_comb begin
		if (next_lsb) begin
			addr_nxt = addr_r + 13'h0001;
		end else begin
			addr_nxt = addr_r - 13'h0001;
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge sclk_i or posedge seq_rst) begin
		if (seq_rst) begin
			state_r <= ST_INSTR;
			rw_r <= 1'b0;
			left_r <= 2'h0;
			addr_r <= 13'h0000;
		end else begin
			case (state_r)
				ST_INSTR: begin
					if (byte_done) begin
						rw_r <= rx_byte[DSCP_INS_RW];
						left_r <= rx_byte[DSCP_INS_CNT_HI:DSCP_INS_CNT_LO];
						addr_r <= {8'h00, rx_byte[DSCP_INS_ADDR_TOP:0]};
						if (long_address_select) begin
							state_r <= ST_ADDR_LO;
						end else begin
							state_r <= ST_DATA;
						end
					end
				end
				ST_ADDR_LO: begin
					if (byte_done) begin
						addr_r <= {addr_r[4:0], rx_byte};
						state_r <= ST_DATA;
					end
				end
				ST_DATA: begin
					if (byte_done) begin
						addr_r <= addr_nxt;
						if (left_r == 2'h0) begin
							state_r <= ST_DONE;
						end else begin
							left_r <= left_r - 2'h1;
						end
					end
				end
				ST_DONE: begin
					// Extra clocks are ignored until select rises
					state_r <= ST_DONE;
				end
				default: begin
					state_r <= ST_INSTR;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	assign reg_q[0] = cfg_r;

	genvar gi;
	generate
		for (gi = 1; gi < DSCP_NUM_REGS; gi++) begin : g_reg
			if (gi == int'(DSCP_REG_VERSION)) begin : g_ro
				assign reg_q[gi] = VERSION_ID;
			end else begin : g_rw
				localparam logic [7:0] DEFV = dscp_def(gi);
				logic [7:0] val_r;
				// Soft reset outranks a write in the same byte
				always_ff @(posedge sclk_i or posedge regs_rst) begin
					if (regs_rst) begin
						val_r <= DEFV;
					end else if (soft_rst) begin
						val_r <= DEFV;
					end else if (wr_en && idx == 5'(gi)) begin
						val_r <= rx_byte;
					end
				end
				assign reg_q[gi] = val_r;
			end
		end
	endgenerate

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Unbacked addresses read as zero rather than aliasing
	always_comb begin
		rd_byte = 8'h00;
		drive_rd = 1'b0;
		if (mapped) begin
			rd_byte = reg_q[idx];
		end
		if (bit_order_select) begin
			tx_idx = bit_cnt_r;
		end else begin
			tx_idx = DSCP_BIT_LAST - bit_cnt_r;
		end
		if (state_r == ST_DATA && rw_r) begin
			drive_rd = 1'b1;
		end
	end

	// Select high releases the line at once, without a clock edge
	always_ff @(negedge sclk_i or posedge seq_rst) begin
		if (seq_rst) begin
			sdio_o <= 1'b0;
			sdio_oe_n_o <= 1'b1;
		end else begin
			sdio_o <= rd_byte[tx_idx];
			sdio_oe_n_o <= !drive_rd;
		end
	end

	// ----------------------------------------
	// Pin mode inputs
	// ----------------------------------------
	dscp_pin_sync #(
		.SETTLE_CYC(SETTLE_CYC)
	) u_pin_sync (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.sclk_i(sclk_i),
		.sdio_i(sdio_i),
		.select_powerdown_n_i(select_powerdown_n_i),
		.port_reset_pinmode_i(port_reset_pinmode_i),
		.pins(pins.prod)
	);

	// ----------------------------------------
	// Register bits into the system clock
	// ----------------------------------------
	// Quasi-static levels, each bit settles on its own
	assign core_src[2] = reg_q[DSCP_REG_CLKMODE][DSCP_CLKMODE_EN_BIT];
	assign core_src[1] = reg_q[DSCP_REG_DATA][DSCP_DATA_FMT_BIT];
	assign core_src[0] = reg_q[DSCP_REG_PWR][DSCP_PWR_DOWN_BIT];

	genvar gs;
	generate
		for (gs = 0; gs < 3; gs++) begin : g_core_sync
			logic meta_r;
			logic sync_r;
			always_ff @(posedge clk_i) begin
				if (srst_i) begin
					meta_r <= 1'b0;
					sync_r <= 1'b0;
				end else begin
					meta_r <= core_src[gs];
					sync_r <= meta_r;
				end
			end
			assign core_sync[gs] = sync_r;
		end
	endgenerate

	// ----------------------------------------
	// Function outputs
	// ----------------------------------------
	// Pin mode overrides the register bits
	always_comb begin
		if (pins.pinmode) begin
			func_nxt = {1'b1, pins.clock_mode_pin, pins.format, pins.pwrdn};
		end else begin
			func_nxt = {1'b0, core_sync};
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pin_mode_o <= 1'b0;
		end else begin
			pin_mode_o <= func_nxt[3];
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			clock_mode_o <= 1'b0;
		end else begin
			clock_mode_o <= func_nxt[2];
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			data_format_o <= 1'b0;
		end else begin
			data_format_o <= func_nxt[1];
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			powerdown_o <= 1'b0;
		end else begin
			powerdown_o <= func_nxt[0];
		end
	end

endmodule

// File: testbench/dscp_chk_sva.sv
`timescale 1ns/10ps
module dscp_chk #(
	parameter int SETTLE_CYC = 100
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic sclk_i,
	input wire logic select_powerdown_n_i,
	input wire logic sdio_i,
	input wire logic sdio_o,
	input wire logic sdio_oe_n_o,
	input wire logic port_reset_pinmode_i,
	input wire logic pin_mode_o,
	input wire logic clock_mode_o,
	input wire logic data_format_o,
	input wire logic powerdown_o
);
	// ----------------
	// Rise counter
	// ----------------
	int rise_cnt;
	// Cleared by select and pin reset like the sequencer, so it counts rises of one cycle
	always_ff @(posedge sclk_i or posedge select_powerdown_n_i
		or posedge port_reset_pinmode_i) begin
		if (select_powerdown_n_i || port_reset_pinmode_i) begin
			rise_cnt <= 0;
		end else if (rise_cnt < 63) begin
			rise_cnt <= rise_cnt + 1;
		end
	end
	// ----------------
	// Properties
	// ----------------
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (srst_i);
	// Three clocks of sync delay, so five still cycles leave margin
	sequence s_pins_still;
		(port_reset_pinmode_i && pin_mode_o && $stable(sclk_i)
			&& $stable(select_powerdown_n_i))[*5];
	endsequence
	AST_OE_DESEL: assert property (
		select_powerdown_n_i |-> sdio_oe_n_o) else $error("line held");
	AST_OE_PINRST: assert property (
		port_reset_pinmode_i |-> sdio_oe_n_o) else $error("line held");
	AST_OUT_ON_FALL: assert property (
		$changed(sdio_o) && !sdio_oe_n_o |-> !sclk_i) else $error("bad edge");
	AST_OE_ON_FALL: assert property (
		$fell(sdio_oe_n_o) |-> !sclk_i) else $error("oe on rise");
	AST_INSTR_FIRST: assert property (
		!sdio_oe_n_o |-> rise_cnt >= 8) else $error("read too soon");
	AST_MAX_BYTES: assert property (
		!sdio_oe_n_o |-> rise_cnt <= 48) else $error("read too long");
	AST_PIN_ENTER: assert property (
		$rose(port_reset_pinmode_i) |-> ##[2:4] pin_mode_o)
		else $error("pin mode late");
	AST_PIN_STEADY: assert property (
		s_pins_still |-> powerdown_o == select_powerdown_n_i
			&& clock_mode_o == sclk_i) else $error("pin not followed");
endmodule
bind dscp_top dscp_chk #(.SETTLE_CYC(SETTLE_CYC)) u_chk (
	.clk_i(clk_i),
	.srst_i(srst_i),
	.sclk_i(sclk_i),
	.select_powerdown_n_i(select_powerdown_n_i),
	.sdio_i(sdio_i),
	.sdio_o(sdio_o),
	.sdio_oe_n_o(sdio_oe_n_o),
	.port_reset_pinmode_i(port_reset_pinmode_i),
	.pin_mode_o(pin_mode_o),
	.clock_mode_o(clock_mode_o),
	.data_format_o(data_format_o),
	.powerdown_o(powerdown_o)
);

// File: testbench/dscp_master.sv
`timescale 1ns/10ps
module dscp_master (
	output logic sclk_o,
	output logic cs_n_o,
	output logic sdio_o,
	input wire logic sdio_i
);
	// ----------------
	// Controller
	// ----------------
	// 48 ns period, under the link ceiling
	localparam int HALF = 24;
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		sdio_o = 1'b0;
	end
	task automatic pins(input logic c, s, d);
		sclk_o = c;
		cs_n_o = s;
		sdio_o = d;
	endtask
	// Select low for the whole cycle, clock rests low
	task automatic start;
		cs_n_o = 1'b0;
		#HALF;
	endtask
	task automatic stop;
		#HALF cs_n_o = 1'b1;
		#HALF;
	endtask
	// Released line toggles, so a stale level is never read back
	task automatic bits(input logic [7:0] tx, input logic lsb, drv,
		input int n, output logic [7:0] rx);
		for (int i = 0; i < n; i++) begin
			sdio_o = !drv ? ~sdio_o : lsb ? tx[i] : tx[7 - i];
			#HALF sclk_o = 1'b1;
			rx = lsb ? {sdio_i, rx[7:1]} : {rx[6:0], sdio_i};
			#HALF sclk_o = 1'b0;
		end
	endtask
	task automatic xfer(input logic [7:0] ins, input logic [4:0] lsb,
		input logic [31:0] wd, input int nb, output logic [31:0] rd);
		logic [7:0] b;
		rd = '0;
		start();
		bits(ins, lsb[0], 1'b1, 8, b);
		for (int k = 0; k < nb; k++) begin
			bits(wd[8*k+:8], lsb[k+1], !ins[7], 8, b);
			rd[8*k+:8] = b;
		end
		stop();
	endtask
endmodule

// File: testbench/tb_dac_serial_config_port.sv
`timescale 1ns/10ps
module tb_dac_serial_config_port
	import dscp_pkg::*;
;
	localparam int SETTLE = 4;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic pin_rst = 1'b0;
	logic sclk;
	logic cs_n;
	logic m_sdio;
	logic line;
	logic sdio_o;
	logic oe_n;
	logic [3:0] fn;
	logic [31:0] rd;
	logic [7:0] b;
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;
	assign line = oe_n ? m_sdio : sdio_o;
	dscp_top #(.SETTLE_CYC(SETTLE)) dut (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.sclk_i(sclk),
		.select_powerdown_n_i(cs_n),
		.sdio_i(line),
		.sdio_o(sdio_o),
		.sdio_oe_n_o(oe_n),
		.port_reset_pinmode_i(pin_rst),
		.pin_mode_o(fn[3]),
		.clock_mode_o(fn[2]),
		.data_format_o(fn[1]),
		.powerdown_o(fn[0])
	);
	dscp_master m (.sclk_o(sclk), .cs_n_o(cs_n), .sdio_o(m_sdio), .sdio_i(line));
	// ----------------
	// Checking
	// ----------------
	task automatic check(input string nm, input logic [31:0] e, a);
		n_tests++;
		if (a !== e) begin
			err_total++;
			$display("mismatch %s exp %h got %h", nm, e, a);
		end
	endtask
	`define CHK(nm, e, a) check(nm, e, a)
	task automatic final_report;
		$display("tests %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ----------------
	// Scenarios
	// ----------------
	task automatic t_defaults;
		m.xfer(8'hC2, 5'h00, 32'h0, 3, rd);
		`CHK("defaults", {DSCP_CFG_RST, DSCP_PWR_RST, DSCP_DATA_RST}, rd);
	endtask
	task automatic t_burst;
		m.xfer(8'h6C, 5'h00, 32'hD4C3B2A1, 4, rd);
		m.xfer(8'hEC, 5'h00, 32'h0, 4, rd);
		`CHK("burst", 32'hD4C3B2A1, rd);
	endtask
	task automatic t_func;
		m.xfer(8'h14, 5'h00, 32'h04, 1, rd);
		m.xfer(8'h02, 5'h00, 32'hB4, 1, rd);
		repeat (8) @(posedge clk_i);
		`CHK("reg functions", 4'h6, fn);
	endtask
	task automatic t_order;
		m.xfer(8'h20, 5'b00100, 32'h2040, 2, rd);
		repeat (6) @(posedge clk_i);
		`CHK("order switch", 1'b1, fn[0]);
		m.xfer(8'h29, 5'h1F, 32'h5A66, 2, rd);
		m.xfer(8'hA9, 5'h1F, 32'h0, 2, rd);
		`CHK("lsb burst", 32'h5A66, rd);
		m.xfer(8'h00, 5'h1F, 32'h60, 1, rd);
		m.xfer(8'h00, 5'h1F, 32'h40, 1, rd);
		m.xfer(8'h80, 5'h1F, 32'h0, 1, rd);
		`CHK("cfg kept", 32'h40, rd);
		m.xfer(8'hA9, 5'h1F, 32'h0, 2, rd);
		`CHK("regs cleared", 32'h0, rd);
		`CHK("pwrdn cleared", 1'b0, fn[0]);
		m.xfer(8'h00, 5'h1F, 32'h0, 1, rd);
	endtask
	// Partial bytes must vanish, whichever way the cycle is cut
	task automatic t_abort;
		m.start();
		m.bits(8'h09, 1'b0, 1'b1, 8, b);
		m.bits(8'hFF, 1'b0, 1'b1, 5, b);
		m.stop();
		m.xfer(8'h89, 5'h00, 32'h0, 1, rd);
		`CHK("cut by select", 32'h0, rd);
		m.start();
		m.bits(8'h02, 1'b0, 1'b1, 8, b);
		m.bits(8'hFF, 1'b0, 1'b1, 5, b);
		@(posedge clk_i);
		pin_rst <= 1'b1;
		repeat (2) @(posedge clk_i);
		pin_rst <= 1'b0;
		repeat (6) @(posedge clk_i);
		m.bits(8'h82, 1'b0, 1'b1, 8, b);
		m.bits(8'h00, 1'b0, 1'b0, 8, b);
		m.stop();
		`CHK("pin reset", DSCP_DATA_RST, b);
	endtask
	task automatic t_pin_mode;
		@(posedge clk_i);
		pin_rst <= 1'b1;
		m.pins(1'b1, 1'b1, 1'b1);
		repeat (SETTLE + 12) @(posedge clk_i);
		`CHK("pins high", 4'hF, fn);
		m.pins(1'b0, 1'b0, 1'b0);
		repeat (SETTLE + 12) @(posedge clk_i);
		`CHK("pins low", 4'h8, fn);
		m.pins(1'b0, 1'b1, 1'b0);
		@(posedge clk_i);
		pin_rst <= 1'b0;
		repeat (8) @(posedge clk_i);
		`CHK("run mode", 4'h0, fn);
	endtask
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		repeat (3) @(posedge clk_i);
		srst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		t_defaults();
		t_burst();
		t_func();
		t_order();
		t_abort();
		t_pin_mode();
		final_report();
	end
	// Whole run needs about two thousand clocks; this ceiling is generous
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			final_report();
		end
	end
endmodule
